// file: tap_pulse_detector_bench.sv
module tap_pulse_detector_bench;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct {
      logic [7:0]  cfg;
      logic [2:0]  rate;
      logic        lp;
      int          ax;
      logic [11:0] amp;
      logic [31:0] pat;
      logic [7:0]  exp;
   } tpd_row_t;

   logic        clk, rst, reg_we, reg_re, reg_hit, status_read, low_power, sample_valid, tap_int;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic [2:0]  output_sample_rate;
   logic [11:0] acc [3];
   int          bad_count, cmp_count, cycles;
   tpd_row_t    rows [13];

   tpd_top #(.STEP_CYCLES(4)) i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
      .reg_hit(reg_hit), .status_read(status_read), .output_sample_rate(output_sample_rate),
      .low_power(low_power), .latency_steps(8'h04), .window_steps(8'h08),
      .sample_valid(sample_valid), .x_accel(acc[0]), .y_accel(acc[1]), .z_accel(acc[2]),
      .tap_int(tap_int));

   // ------------------------------------------------
   // clock and hang guard
   // ------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // cut a hang short
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         bad_count++;
         tally_and_finish();
      end
   end

   // ------------------------------------------------
   // tasks
   // ------------------------------------------------
   task automatic tally_and_finish();
      if (bad_count == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge clk);
      reg_we <= 1'b0;
   endtask

   // read and compare, data settled after the taking edge
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge clk);
      reg_re <= 1'b0;
      @(negedge clk);
      check(reg_rdata, e);
   endtask

   // one sample every four cycles, other axes quiet
   task automatic smp(input int ax, input logic [11:0] v);
      @(posedge clk);
      foreach (acc[i]) acc[i] <= (i == ax) ? v : 12'h000;
      sample_valid <= 1'b1;
      @(posedge clk);
      sample_valid <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   task automatic clear_int();
      @(posedge clk);
      status_read <= 1'b1;
      @(posedge clk);
      status_read <= 1'b0;
      @(negedge clk);
      check({7'h00, tap_int}, 8'h00);
   endtask

   task automatic run_row(input tpd_row_t r);
      wr(8'h2F, r.cfg);
      output_sample_rate <= r.rate;
      low_power <= r.lp;
      for (int i = 0; i < 32; i++)
         smp(r.ax, r.pat[i] ? r.amp : 12'h000);
      repeat (200) @(posedge clk);
      @(negedge clk);
      check({7'h00, tap_int}, {7'h00, r.exp != 8'h00});
      rdc(8'h30, r.exp);
      rdc(8'h30, 8'h00);
      clear_int();
   endtask

   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial
   begin
      rows = '{
         '{8'h41, 3'h0, 1'b0, 0, 12'h200, 32'h00000003, 8'h41},
         '{8'h44, 3'h0, 1'b0, 1, 12'h200, 32'h00000003, 8'h44},
         '{8'h50, 3'h0, 1'b0, 2, 12'hE00, 32'h00000003, 8'h50},
         '{8'h6A, 3'h0, 1'b0, 1, 12'h200, 32'h0000C003, 8'h48},
         '{8'h54, 3'h0, 1'b0, 0, 12'h200, 32'h00000003, 8'h00},
         '{8'h41, 3'h0, 1'b0, 0, 12'h200, 32'h00007FFF, 8'h00},
         '{8'h41, 3'h0, 1'b1, 0, 12'h200, 32'h00007FFF, 8'h41},
         '{8'h41, 3'h1, 1'b0, 0, 12'h200, 32'h00007FFF, 8'h41},
         '{8'h43, 3'h0, 1'b0, 0, 12'h200, 32'h0000C00B, 8'h43},
         '{8'hC3, 3'h0, 1'b0, 0, 12'h200, 32'h0000C00B, 8'h41},
         '{8'h60, 3'h0, 1'b0, 2, 12'h200, 32'h0000C003, 8'h60},
         '{8'h41, 3'h0, 1'b0, 0, 12'h085, 32'h00000003, 8'h41},
         '{8'h41, 3'h0, 1'b0, 0, 12'h084, 32'h00000003, 8'h00}};
      rst = 1'b1;
      reg_we = 1'b0;
      reg_re = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      status_read = 1'b0;
      low_power = 1'b0;
      sample_valid = 1'b0;
      output_sample_rate = 3'h0;
      foreach (acc[i]) acc[i] = 12'h000;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int a = 8'h2F; a <= 8'h34; a++)
      begin
         rdc(8'(a), 8'h00);
         check({7'h00, reg_hit}, 8'h01);
      end
      wr(8'h2F, 8'hA5);
      rdc(8'h2F, 8'hA5);
      rdc(8'h35, 8'h00);
      check({7'h00, reg_hit}, 8'h00);
      wr(8'h31, 8'hFF);
      rdc(8'h31, 8'h1F);
      wr(8'h30, 8'hFF);
      rdc(8'h30, 8'h00);
      for (int a = 8'h31; a <= 8'h33; a++)
         wr(8'(a), 8'h02);
      wr(8'h34, 8'h0A);
      foreach (rows[i]) run_row(rows[i]);
      wr(8'h2F, 8'h01);
      output_sample_rate <= 3'h0;
      low_power <= 1'b0;
      smp(0, 12'h200);
      smp(0, 12'h200);
      smp(0, 12'h000);
      rdc(8'h30, 8'h41);
      smp(0, 12'h000);
      rdc(8'h30, 8'h00);
      clear_int();
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rdc(8'h2F, 8'h00);
      rdc(8'h31, 8'h00);
      tally_and_finish();
   end
endmodule

// file: tpd_axis.sv
module tpd_axis
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // sample and timing strobes
   input  wire logic       sample_valid,
   input  wire logic       above,
   input  wire logic       step_tick,
   input  wire logic       ltcy_tick,
   // settings
   input  wire logic [7:0] time_limit,
   input  wire logic [7:0] latency_steps,
   input  wire logic [7:0] window_steps,
   input  wire logic       double_tap_abort,
   // detections
   output logic            single_evt,
   output logic            double_evt
);

   tpd_pkg::tpd_state_t state;
   logic [7:0] cnt;
   logic       seen_start;
   logic       aborted;

   // pulse, latency and window sequencing
   always_ff @(posedge clk)
   begin
      single_evt <= 1'b0;
      double_evt <= 1'b0;
      if (rst)
      begin
         state      <= tpd_pkg::TPD_IDLE;
         cnt        <= 8'h00;
         seen_start <= 1'b0;
         aborted    <= 1'b0;
      end
      else
      begin
         case (state)
            tpd_pkg::TPD_IDLE:
            begin
               cnt <= 8'h00;
               if (sample_valid && above)
                  state <= tpd_pkg::TPD_PULSE1;
            end
            tpd_pkg::TPD_PULSE1, tpd_pkg::TPD_PULSE2:
            begin
               if (step_tick)
                  cnt <= cnt + 8'h01;
               if (step_tick && cnt >= time_limit)
                  state <= tpd_pkg::TPD_WAIT_LOW;
               else if (sample_valid && !above)
               begin
                  single_evt <= (state == tpd_pkg::TPD_PULSE1);
                  double_evt <= (state == tpd_pkg::TPD_PULSE2);
                  cnt        <= 8'h00;
                  seen_start <= 1'b0;
                  aborted    <= 1'b0;
                  state      <= (state == tpd_pkg::TPD_PULSE1) ?
                                tpd_pkg::TPD_LATENCY : tpd_pkg::TPD_IDLE;
               end
            end
            tpd_pkg::TPD_LATENCY:
            begin
               if (ltcy_tick)
                  cnt <= cnt + 8'h01;
               if (sample_valid && above)
                  seen_start <= 1'b1;
               if (sample_valid && !above && seen_start && double_tap_abort)
                  aborted <= 1'b1;
               if (ltcy_tick && cnt + 8'h01 >= latency_steps)
               begin
                  cnt <= 8'h00;
                  state <= aborted ? tpd_pkg::TPD_IDLE : tpd_pkg::TPD_WINDOW;
               end
            end
            tpd_pkg::TPD_WINDOW:
            begin
               if (ltcy_tick)
                  cnt <= cnt + 8'h01;
               if (sample_valid && above)
               begin
                  cnt   <= 8'h00;
                  state <= tpd_pkg::TPD_PULSE2;
               end
               else if (ltcy_tick && cnt + 8'h01 >= window_steps)
                  state <= tpd_pkg::TPD_IDLE;
            end
            tpd_pkg::TPD_WAIT_LOW:
            begin
               if (sample_valid && !above)
                  state <= tpd_pkg::TPD_IDLE;
            end
            default:
               state <= tpd_pkg::TPD_IDLE;
         endcase
      end
   end

endmodule

// file: tpd_monitor.sv
module tpd_monitor
#(
   parameter int STEP_CYCLES = 4
)
(
   // clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_we,
   input wire logic       reg_re,
   input wire logic [7:0] reg_rdata,
   input wire logic       reg_hit,
   // event
   input wire logic       status_read,
   input wire logic       tap_int
);
   // ------------------------------------------------
   // properties
   // ------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   logic mapped;

   // address decode of the register window
   assign mapped = reg_addr >= tpd_pkg::ADDR_CONFIG && reg_addr <= tpd_pkg::ADDR_TMLT;

   property p_rst_quiet;
      disable iff (1'b0) rst |=> reg_rdata == 8'h00 && !reg_hit && !tap_int;
   endproperty
   property p_thr_upper;
      reg_re && reg_addr >= tpd_pkg::ADDR_THR_X && reg_addr <= tpd_pkg::ADDR_THR_Z
         |=> reg_rdata[7:5] == 3'h0;
   endproperty
   property p_src_top;
      reg_re && reg_addr == tpd_pkg::ADDR_SOURCE |=> !reg_rdata[7];
   endproperty
   property p_event_active;
      reg_re && reg_addr == tpd_pkg::ADDR_SOURCE |=> reg_rdata[6] == |reg_rdata[5:0];
   endproperty
   property p_int_clear;
      $fell(tap_int) |-> $past(status_read);
   endproperty
   property p_cfg_back;
      reg_we && reg_addr == tpd_pkg::ADDR_CONFIG ##2 reg_re && !reg_we
         && reg_addr == tpd_pkg::ADDR_CONFIG |=> reg_rdata == $past(reg_wdata, 3);
   endproperty
   property p_thr_back;
      reg_we && reg_addr == tpd_pkg::ADDR_THR_X ##2 reg_re && !reg_we
         && reg_addr == tpd_pkg::ADDR_THR_X |=> reg_rdata[4:0] == $past(reg_wdata[4:0], 3);
   endproperty
   property p_unmapped;
      reg_re && !mapped |=> reg_rdata == 8'h00 && !reg_hit;
   endproperty

   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not cleared");
   a_thr_upper: assert property (p_thr_upper) else $error("threshold upper bits set");
   a_src_top: assert property (p_src_top) else $error("source bit 7 set");
   a_event_active: assert property (p_event_active) else $error("event active wrong");
   a_int_clear: assert property (p_int_clear) else $error("tap_int fell alone");
   a_cfg_back: assert property (p_cfg_back) else $error("config readback wrong");
   a_thr_back: assert property (p_thr_back) else $error("threshold readback wrong");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not empty");

   // main scenarios seen
   c_event: cover property (reg_re && reg_addr == tpd_pkg::ADDR_SOURCE ##1 reg_rdata[6]);
   c_int: cover property ($rose(tap_int));
   c_clear: cover property ($fell(tap_int));
endmodule

bind tpd_top tpd_monitor #(.STEP_CYCLES(STEP_CYCLES)) i_monitor (.clk(clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
   .reg_rdata(reg_rdata), .reg_hit(reg_hit), .status_read(status_read), .tap_int(tap_int));

// file: tpd_pkg.sv
package tpd_pkg;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CONFIG = 8'h2F;
   localparam logic [7:0] ADDR_SOURCE = 8'h30;
   localparam logic [7:0] ADDR_THR_X  = 8'h31;
   localparam logic [7:0] ADDR_THR_Y  = 8'h32;
   localparam logic [7:0] ADDR_THR_Z  = 8'h33;
   localparam logic [7:0] ADDR_TMLT   = 8'h34;

   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int CFG_ABORT_BIT = 7;
   localparam int CFG_LATCH_BIT = 6;
   localparam int SRC_ANY_BIT   = 6;
   localparam int THR_W         = 5;
   localparam logic [7:0] CONFIG_RST = 8'h00;
   localparam logic [4:0] THR_RST    = 5'h00;
   localparam logic [7:0] TMLT_RST   = 8'h00;
   localparam logic [5:0] FLAGS_RST  = 6'h00;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_PS   = 20000;
   localparam int STEP_MIN_PS     = 625000000; // 0.625 ms
   localparam int STEP_BASE_CYCLES = STEP_MIN_PS / CLK_PERIOD_PS;
   localparam logic [2:0] RATE_MAX_SHIFT = 3'h3; // 50 Hz and slower
   // one threshold count in sample lsbs (0.258 g over 3.906 mg)
   localparam logic [11:0] LSB_PER_COUNT = 12'h042;

   // ---------------------------------------------------------------
   // per-axis detector states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      TPD_IDLE,
      TPD_PULSE1,
      TPD_LATENCY,
      TPD_WINDOW,
      TPD_PULSE2,
      TPD_WAIT_LOW
   } tpd_state_t;

endpackage

// file: tpd_top.sv
module tpd_top
#(
   parameter int STEP_CYCLES = tpd_pkg::STEP_BASE_CYCLES
)
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_we,
   input  wire logic        reg_re,
   output logic      [7:0]  reg_rdata,
   output logic             reg_hit,
   // status register read strobe
   input  wire logic        status_read,
   // rate and power mode
   input  wire logic [2:0]  output_sample_rate,
   input  wire logic        low_power,
   // latency and second window settings
   input  wire logic [7:0]  latency_steps,
   input  wire logic [7:0]  window_steps,
   // acceleration samples, 8g scale
   input  wire logic        sample_valid,
   input  wire logic [11:0] x_accel,
   input  wire logic [11:0] y_accel,
   input  wire logic [11:0] z_accel,
   // tap event pending
   output logic             tap_int
);

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   logic [7:0] tap_config;
   logic [4:0] x_tap_level;
   logic [4:0] y_tap_level;
   logic [4:0] z_tap_level;
   logic [7:0] tap_time_limit;
   logic [5:0] flags;

   logic double_tap_abort;
   logic flag_latch_on;
   logic z_double_tap_enable;
   logic z_single_tap_enable;
   logic y_double_tap_enable;
   logic y_single_tap_enable;
   logic x_double_tap_enable;
   logic x_single_tap_enable;
   logic event_active;

   assign double_tap_abort    = tap_config[tpd_pkg::CFG_ABORT_BIT];
   assign flag_latch_on       = tap_config[tpd_pkg::CFG_LATCH_BIT];
   assign z_double_tap_enable = tap_config[5];
   assign z_single_tap_enable = tap_config[4];
   assign y_double_tap_enable = tap_config[3];
   assign y_single_tap_enable = tap_config[2];
   assign x_double_tap_enable = tap_config[1];
   assign x_single_tap_enable = tap_config[0];

   // -----------------------------------------------------------------
   // threshold compare
   // -----------------------------------------------------------------

   // magnitude of a two's complement sample
   function automatic logic [11:0] magnitude(input logic [11:0] a);
      magnitude = a[11] ? 12'(~a + 12'h001) : a;
   endfunction

   // true when the sample magnitude is above the scaled threshold
   function automatic logic exceeds(input logic [11:0] a, input logic [4:0] thr);
      logic [16:0] scaled;
      scaled  = 17'(thr) * 17'(tpd_pkg::LSB_PER_COUNT);
      exceeds = 17'(magnitude(a)) > scaled;
   endfunction

   logic x_above;
   logic y_above;
   logic z_above;

   assign x_above = exceeds(x_accel, x_tap_level);
   assign y_above = exceeds(y_accel, y_tap_level);
   assign z_above = exceeds(z_accel, z_tap_level);

   // -----------------------------------------------------------------
   // time steps
   // -----------------------------------------------------------------
   logic [31:0] base_cnt;
   logic        base_tick;
   logic [4:0]  pre_cnt;
   logic [4:0]  step_len;
   logic [2:0]  rate_shift;
   logic        step_tick;
   logic        half;
   logic        ltcy_tick;

   assign rate_shift = (output_sample_rate > tpd_pkg::RATE_MAX_SHIFT) ?
                       tpd_pkg::RATE_MAX_SHIFT : output_sample_rate;
   assign step_len   = 5'(5'h01 << (rate_shift + 3'(low_power)));

   always_ff @(posedge clk)
   begin
      if (rst || base_tick)
         base_cnt <= 32'h00000000;
      else
         base_cnt <= base_cnt + 32'h00000001;
   end

   assign base_tick = (base_cnt == 32'(STEP_CYCLES - 1));

   // step prescaler in base steps
   always_ff @(posedge clk)
   begin
      if (rst)
         pre_cnt <= 5'h00;
      else if (base_tick)
         pre_cnt <= (pre_cnt + 5'h01 >= step_len) ? 5'h00 : pre_cnt + 5'h01;
   end

   assign step_tick = base_tick && (pre_cnt + 5'h01 >= step_len);

   // latency and window steps run at half the limit rate
   always_ff @(posedge clk)
   begin
      if (rst)
         half <= 1'b0;
      else if (step_tick)
         half <= ~half;
   end

   assign ltcy_tick = step_tick && half;

   // -----------------------------------------------------------------
   // per-axis detectors
   // -----------------------------------------------------------------
   logic [2:0] single_evt;
   logic [2:0] double_evt;

   tpd_axis u_axis_x
   (
      .clk              (clk),
      .rst              (rst),
      .sample_valid     (sample_valid),
      .above            (x_above),
      .step_tick        (step_tick),
      .ltcy_tick        (ltcy_tick),
      .time_limit       (tap_time_limit),
      .latency_steps    (latency_steps),
      .window_steps     (window_steps),
      .double_tap_abort (double_tap_abort),
      .single_evt       (single_evt[0]),
      .double_evt       (double_evt[0])
   );

   tpd_axis u_axis_y
   (
      .clk              (clk),
      .rst              (rst),
      .sample_valid     (sample_valid),
      .above            (y_above),
      .step_tick        (step_tick),
      .ltcy_tick        (ltcy_tick),
      .time_limit       (tap_time_limit),
      .latency_steps    (latency_steps),
      .window_steps     (window_steps),
      .double_tap_abort (double_tap_abort),
      .single_evt       (single_evt[1]),
      .double_evt       (double_evt[1])
   );

   tpd_axis u_axis_z
   (
      .clk              (clk),
      .rst              (rst),
      .sample_valid     (sample_valid),
      .above            (z_above),
      .step_tick        (step_tick),
      .ltcy_tick        (ltcy_tick),
      .time_limit       (tap_time_limit),
      .latency_steps    (latency_steps),
      .window_steps     (window_steps),
      .double_tap_abort (double_tap_abort),
      .single_evt       (single_evt[2]),
      .double_evt       (double_evt[2])
   );

   // -----------------------------------------------------------------
   // source flags
   // -----------------------------------------------------------------
   logic [5:0] new_events;
   logic       src_read;
   logic [5:0] next_flags;

   assign new_events = {double_evt[2] && z_double_tap_enable,
                        single_evt[2] && z_single_tap_enable,
                        double_evt[1] && y_double_tap_enable,
                        single_evt[1] && y_single_tap_enable,
                        double_evt[0] && x_double_tap_enable,
                        single_evt[0] && x_single_tap_enable};

   assign src_read = reg_re && (reg_addr == tpd_pkg::ADDR_SOURCE);

   // flag update, latched or following
   always_comb
   begin
      next_flags = flags;
      if (flag_latch_on)
      begin
         if (src_read)
            next_flags = 6'h00;
         next_flags = next_flags | new_events;
      end
      else
         next_flags = sample_valid ? new_events : (flags | new_events);
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         flags <= tpd_pkg::FLAGS_RST;
      else
         flags <= next_flags;
   end

   assign event_active = |flags;

   always_ff @(posedge clk)
   begin
      if (rst)
         tap_int <= 1'b0;
      else if (|new_events)
         tap_int <= 1'b1;
      else if (status_read)
         tap_int <= 1'b0;
   end

   // -----------------------------------------------------------------
   // register writes
   // -----------------------------------------------------------------

   always_ff @(posedge clk)
   begin
      if (rst)
         tap_config <= tpd_pkg::CONFIG_RST;
      else if (reg_we && reg_addr == tpd_pkg::ADDR_CONFIG)
         tap_config <= reg_wdata;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         x_tap_level <= tpd_pkg::THR_RST;
         y_tap_level <= tpd_pkg::THR_RST;
         z_tap_level <= tpd_pkg::THR_RST;
      end
      else if (reg_we)
      begin
         if (reg_addr == tpd_pkg::ADDR_THR_X)
            x_tap_level <= reg_wdata[4:0];
         if (reg_addr == tpd_pkg::ADDR_THR_Y)
            y_tap_level <= reg_wdata[4:0];
         if (reg_addr == tpd_pkg::ADDR_THR_Z)
            z_tap_level <= reg_wdata[4:0];
      end
   end

   // time limit register
   always_ff @(posedge clk)
   begin
      if (rst)
         tap_time_limit <= tpd_pkg::TMLT_RST;
      else if (reg_we && reg_addr == tpd_pkg::ADDR_TMLT)
         tap_time_limit <= reg_wdata;
   end

   // -----------------------------------------------------------------
   // register reads
   // -----------------------------------------------------------------
   logic [7:0] next_rdata;
   logic       next_hit;

   // read mux, unmapped reads as zero
   always_comb
   begin
      next_rdata = 8'h00;
      next_hit   = 1'b1;
      case (reg_addr)
         tpd_pkg::ADDR_CONFIG: next_rdata = tap_config;
         tpd_pkg::ADDR_SOURCE: next_rdata = {1'b0, event_active, flags};
         tpd_pkg::ADDR_THR_X:  next_rdata = {3'h0, x_tap_level};
         tpd_pkg::ADDR_THR_Y:  next_rdata = {3'h0, y_tap_level};
         tpd_pkg::ADDR_THR_Z:  next_rdata = {3'h0, z_tap_level};
         tpd_pkg::ADDR_TMLT:   next_rdata = tap_time_limit;
         default:              next_hit   = 1'b0;
      endcase
   end

   // read data captured on the read strobe
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         reg_rdata <= 8'h00;
         reg_hit   <= 1'b0;
      end
      else if (reg_re)
      begin
         reg_rdata <= next_rdata;
         reg_hit   <= next_hit;
      end
   end

endmodule
